/* hdl/fpa_host.sv */
// How it works
// - One feature address byte per command; four parameter bytes follow it.
// - Host waits the address-to-data delay before the first parameter byte.
// - Host polls ready pin, never status, so no read-mode reissue needed.
// - Host never issues the enhanced status command.
// - Four parameter bytes read back in order, first byte first.
// - Software picks the timing mode matching host strobe speed.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fpa_host
  import fpa_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic chip_enable_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  import fpa_pkg::*;

  fpa_state_e st;
  logic [7:0] cnt;
  logic [1:0] idx;
  logic set_op;
  logic [7:0] fa;
  logic [7:0] p1;
  logic [31:0] result;
  logic done;
  logic refused;
  logic [7:0] interface_speed_select;
  logic [7:0] array_behaviour_select;
  logic [7:0] io_m, io_s;
  logic rb_m, rb_s;
  logic aw_hs, ar_hs, start_wr;
  logic fa_valid;
  logic [7:0] p1_sent;
  logic wr_end, rd_end;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    io_m <= io_in;
    io_s <= io_m;
    rb_m <= ready_busy_n;
    rb_s <= rb_m;
  end

  // ---------------------------------------------------------------
  // Feature decode and parameter shaping
  // ---------------------------------------------------------------
  // address decode
  assign fa_valid = (fa == FA_SPEED) || (fa == FA_DRIVE) || (fa == FA_RB_PULL) ||
    (fa == FA_ARRAY);
  always_comb begin
    case (fa)
      FA_SPEED: p1_sent = p1 & MASK_SPEED;
      FA_DRIVE, FA_RB_PULL: p1_sent = p1 & MASK_STRENGTH;
      FA_ARRAY: p1_sent = p1 & MASK_ARRAY;
      default: p1_sent = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign aw_hs = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = aw_hs;
  assign s_axi_wready = aw_hs;
  assign ar_hs = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign start_wr = aw_hs && (s_axi_awaddr == OFS_CTRL) && s_axi_wstrb[0] &&
    s_axi_wdata[CTRL_START];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aw_hs) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == OFS_CTRL || s_axi_awaddr == OFS_PARAM) ?
        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= {16'h0000, fa, 6'h00, set_op, 1'b0};
        OFS_PARAM: s_axi_rdata <= {24'h000000, p1};
        OFS_RESULT: s_axi_rdata <= result;
        OFS_STATUS: s_axi_rdata <= {8'h00, array_behaviour_select,
          interface_speed_select, 5'h00, refused, done, st != FPA_IDLE};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Request fields frozen while a transfer runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fa <= 8'h00;
      set_op <= 1'b0;
      p1 <= 8'h00;
    end else if (aw_hs && st == FPA_IDLE) begin
      if (s_axi_awaddr == OFS_CTRL) begin
        if (s_axi_wstrb[0])
          set_op <= s_axi_wdata[CTRL_SET];
        if (s_axi_wstrb[1])
          fa <= s_axi_wdata[CTRL_FA_LSB +: 8];
      end
      if (s_axi_awaddr == OFS_PARAM && s_axi_wstrb[0])
        p1 <= s_axi_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic start_pend;
  assign wr_end = (cnt == 8'(WE_LO + WE_HI - 1));
  assign rd_end = (cnt == 8'(RE_LO + RE_HI - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn)
      start_pend <= 1'b0;
    else
      start_pend <= start_wr && st == FPA_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= FPA_IDLE;
      cnt <= 8'h00;
      idx <= 2'b00;
    end else begin
      cnt <= cnt + 8'h01;
      case (st)
        FPA_IDLE: begin
          cnt <= 8'h00;
          idx <= 2'b00;
          if (start_pend && fa_valid && rb_s)
            st <= FPA_CMD;
        end
        FPA_CMD: if (wr_end) begin
          st <= FPA_ADDR;
          cnt <= 8'h00;
        end
        FPA_ADDR: if (wr_end) begin
          st <= set_op ? FPA_ADL : FPA_WB;
          cnt <= 8'h00;
        end
        FPA_ADL: if (cnt == 8'(ADL_CYC - 1)) begin
          st <= FPA_WR;
          cnt <= 8'h00;
        end
        FPA_WR: if (wr_end) begin
          cnt <= 8'h00;
          idx <= idx + 2'b01;
          if (idx == 2'b11)
            st <= FPA_WB;
        end
        FPA_WB: if (cnt == 8'(WB_CYC - 1))
          st <= FPA_BUSY;
        FPA_BUSY: begin
          cnt <= 8'h00;
          idx <= 2'b00;
          if (rb_s)
            st <= set_op ? FPA_IDLE : FPA_RD;
        end
        FPA_RD: if (rd_end) begin
          cnt <= 8'h00;
          idx <= idx + 2'b01;
          if (idx == 2'b11)
            st <= FPA_IDLE;
        end
        default: st <= FPA_IDLE;
      endcase
    end
  end

  // Sample late in the low phase; synchroniser adds two cycles
  always_ff @(posedge aclk) begin
    if (!aresetn)
      result <= 32'h0000_0000;
    else if (st == FPA_RD && cnt == 8'(RE_LO))
      result[idx*8 +: 8] <= io_s;
  end

  // ---------------------------------------------------------------
  // Status and shadows
  // ---------------------------------------------------------------
  logic finish;
  assign finish = (st == FPA_BUSY && rb_s && set_op) ||
    (st == FPA_RD && rd_end && idx == 2'b11);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      refused <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (start_pend && st == FPA_IDLE) begin
      done <= 1'b0;
      refused <= !(fa_valid && rb_s);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interface_speed_select <= RESET_SPEED;
      array_behaviour_select <= RESET_ARRAY;
    end else if (finish) begin
      if (fa == FA_SPEED)
        interface_speed_select <= set_op ? p1_sent : result[7:0];
      if (fa == FA_ARRAY)
        array_behaviour_select <= set_op ? p1_sent : result[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Registered pin drive
  // ---------------------------------------------------------------
  logic wr_phase;
  assign wr_phase = (st == FPA_CMD) || (st == FPA_ADDR) || (st == FPA_WR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_enable_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_oe <= 1'b0;
      io_out <= 8'h00;
    end else begin
      chip_enable_n <= (st == FPA_IDLE);
      cmd_latch <= (st == FPA_CMD);
      addr_latch <= (st == FPA_ADDR);
      write_strobe_n <= !(wr_phase && cnt < 8'(WE_LO));
      read_strobe_n <= !(st == FPA_RD && cnt < 8'(RE_LO));
      io_oe <= wr_phase;
      // only EFh or EEh ever driven as command
      if (st == FPA_CMD)
        io_out <= set_op ? CMD_SET_FEAT : CMD_GET_FEAT;
      else if (st == FPA_ADDR)
        io_out <= fa;
      else if (st == FPA_WR)
        io_out <= (idx == 2'b00) ? p1_sent : 8'h00;
      else
        io_out <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_adl;
    $rose(st == FPA_ADL) |-> (st == FPA_ADL)[*7] ##1 (st == FPA_WR);
  endproperty
  a_adl: assert property (p_adl) else $error("address to data delay wrong");

  property p_ready_start;
    $rose(st == FPA_CMD) |-> $past(rb_s) && fa_valid;
  endproperty
  a_ready_start: assert property (p_ready_start) else $error("start while busy");

  property p_zero_upper;
    (st == FPA_WR && idx != 2'b00) |=> io_out == 8'h00;
  endproperty
  a_zero_upper: assert property (p_zero_upper) else $error("nonzero P2-P4");

  property p_speed_mask;
    (st == FPA_WR && idx == 2'b00 && fa == FA_SPEED) |=> io_out[7:3] == 5'h00;
  endproperty
  a_speed_mask: assert property (p_speed_mask) else $error("timing mode bits");

  property p_array_mask;
    (st == FPA_WR && idx == 2'b00 && fa == FA_ARRAY) |=> (io_out & ~MASK_ARRAY) == 8'h00;
  endproperty
  a_array_mask: assert property (p_array_mask) else $error("array mode bits");

  property p_busy_hold;
    (st == FPA_BUSY && !rb_s) |=> st == FPA_BUSY;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("left busy early");

  property p_cmd_code;
    $rose(cmd_latch) |-> io_oe && (io_out == (set_op ? CMD_SET_FEAT : CMD_GET_FEAT));
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad command code");

  property p_four_bytes;
    $rose(st == FPA_WB) && set_op |-> $past(idx) == 2'b11 && $past(st) == FPA_WR;
  endproperty
  a_four_bytes: assert property (p_four_bytes) else $error("byte count");

  property p_no_contend;
    !(io_oe && !read_strobe_n);
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("bus contention");

endmodule // fpa_host
`default_nettype wire

/* hdl/fpa_pkg.sv */
package fpa_pkg;
  localparam int CLK_MHZ = 100;
  // ---------------------------------------------------------------
  // Own register map (AXI4-Lite byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PARAM = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_SET = 1;
  localparam int CTRL_FA_LSB = 8;
  localparam int ST_ACTIVE = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SPEED_LSB = 8;
  localparam int ST_ARRAY_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // Device command codes, feature addresses, field masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] FA_SPEED = 8'h01;
  localparam logic [7:0] FA_DRIVE = 8'h80;
  localparam logic [7:0] FA_RB_PULL = 8'h81;
  localparam logic [7:0] FA_ARRAY = 8'h90;
  localparam logic [7:0] MASK_SPEED = 8'h07;
  localparam logic [7:0] MASK_STRENGTH = 8'h03;
  localparam logic [7:0] MASK_ARRAY = 8'h1B;
  localparam logic [7:0] RESET_SPEED = 8'h00;
  localparam logic [7:0] RESET_ARRAY = 8'h00;
  // ---------------------------------------------------------------
  // Pin timing
  // ---------------------------------------------------------------
  localparam int WE_LO_NS = 25;
  localparam int WE_HI_NS = 15;
  localparam int RE_LO_NS = 60;
  localparam int RE_HI_NS = 20;
  localparam int ADDRESS_TO_DATA_DELAY_NS = 70;
  localparam int WB_NS = 100;
  localparam int WE_LO = (WE_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_HI = (WE_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int RE_LO = (RE_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int RE_HI = (RE_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int ADL_CYC = (ADDRESS_TO_DATA_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    FPA_IDLE = 3'b000,
    FPA_CMD = 3'b001,
    FPA_ADDR = 3'b010,
    FPA_ADL = 3'b011,
    FPA_WR = 3'b100,
    FPA_WB = 3'b101,
    FPA_BUSY = 3'b110,
    FPA_RD = 3'b111
  } fpa_state_e;
endpackage

/* tb/fpa_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpa_flash_model
  import fpa_pkg::*;
#(
  parameter int FEATURE_BUSY_NS = 300,
  parameter int ITC_BUSY_NS = 800,
  parameter int OTP_BUSY_NS = 500,
  parameter int OTP_BUSY_ECC_NS = 700
) (
  // Host side pins
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  // Device answers
  output logic [7:0] io_in,
  output logic ready_busy_n,
  // Bench controls
  input wire logic power_cycle,
  input wire logic force_busy
);
  logic [7:0] feat [256];
  logic [7:0] cmd = 8'h00;
  logic [7:0] fa = 8'h00;
  logic [7:0] p1;
  logic [7:0] extra_or = 8'h00;
  logic [7:0] dq = 8'h5A;
  logic busy;
  logic lock_off;
  logic known = 1'b0;
  int idx;
  int ns;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign io_in = io_oe ? io_out : dq;
  assign ready_busy_n = ~(busy | force_busy);
  task automatic hold_busy(input int t);
    busy = 1'b1;
    #(t);
    busy = 1'b0;
  endtask
  task automatic defaults();
    foreach (feat[i]) feat[i] = 8'h00;
    lock_off = 1'b0;
    busy = 1'b0;
  endtask
  initial defaults();
  always @(posedge power_cycle) defaults();
  always @(posedge write_strobe_n) begin
    if (!chip_enable_n && cmd_latch) begin
      // mode kept until next command; get ignored while busy
      cmd = (io_out == CMD_GET_FEAT && !ready_busy_n) ? 8'h00 : io_out;
      idx = 0;
      extra_or = 8'h00;
    end else if (!chip_enable_n && addr_latch) begin
      fa = io_out;
      idx = 0;
      known = fa inside {FA_SPEED, FA_DRIVE, FA_RB_PULL, FA_ARRAY};
      if (cmd == CMD_GET_FEAT && known) hold_busy(FEATURE_BUSY_NS);
    end else if (!chip_enable_n && cmd == CMD_SET_FEAT && known) begin
      // one byte per rising strobe, first byte first
      if (idx == 0) p1 = io_out;
      else extra_or = extra_or | io_out;
      idx++;
      if (idx == 4) begin
        // feature, interface change or lock repeat time
        if (fa == FA_ARRAY && p1 == 8'h10 && lock_off) begin
          ns = feat[FA_ARRAY][3] ? OTP_BUSY_ECC_NS : OTP_BUSY_NS;
        end else if (fa == FA_SPEED && p1 != feat[FA_SPEED]) ns = ITC_BUSY_NS;
        else ns = FEATURE_BUSY_NS;
        if (fa == FA_ARRAY && p1 == 8'h10) lock_off = 1'b1;
        feat[fa] = p1;
        hold_busy(ns);
      end
    end
  end
  // bytes leave in order, second to fourth zero
  always @(negedge read_strobe_n) begin
    if (!chip_enable_n && cmd == CMD_GET_FEAT && known) begin
      #20 dq = (idx == 0) ? feat[fa] : 8'h00;
      idx++;
    end
  end
  always @(posedge read_strobe_n) #5 dq = ~dq;
endmodule // fpa_flash_model
`default_nettype wire

/* tb/tb_feature_parameter_access.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_feature_parameter_access;
  import fpa_pkg::*;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awvalid, wvalid, arvalid, power_cycle, force_busy;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic chip_enable_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
  logic [7:0] io_out, io_in;
  int fails = 0;
  int num_checks = 0;
  int ce_falls = 0;
  logic [7:0] t_fa [22] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h90, 8'h90, 8'h90,
    8'h90, 8'h90, 8'h90, 8'h90, 8'h80, 8'h80, 8'h80, 8'h80, 8'h81, 8'h81, 8'h81, 8'h81};
  logic [7:0] t_p1 [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hFF, 8'h00, 8'h01, 8'h03,
    8'h08, 8'h10, 8'h10, 8'h1F, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] rsv [5] = '{8'h00, 8'h02, 8'h7F, 8'h82, 8'hFF};
  fpa_host uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n)
  );
  fpa_flash_model flash (
    .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n),
    .power_cycle(power_cycle), .force_busy(force_busy)
  );
  always @(negedge chip_enable_n) ce_falls++;
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n > 3000) begin
      fails++;
      $display("CHECK FAILED wait expected answer seen timeout");
      tally_and_finish();
    end
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      guard(n);
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
      guard(n);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  // Start one transfer, then poll status until it settles
  task automatic op(input logic set, input logic [7:0] fa, input logic [7:0] p1,
                    output logic [31:0] st);
    logic [1:0] r;
    int n;
    n = 0;
    wr(OFS_PARAM, {24'h0, p1}, r);
    wr(OFS_CTRL, {16'h0, fa, 6'h0, set, 1'b1}, r);
    do begin
      rd(OFS_STATUS, st, r);
      n++;
      guard(n);
    end while (st[ST_ACTIVE] !== 1'b0 || (st[ST_DONE] !== 1'b1 && st[ST_REFUSED] !== 1'b1));
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] st, d;
    logic [1:0] r;
    logic [7:0] exp;
    int n;
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    power_cycle = 1'b0;
    force_busy = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      rd(OFS_STATUS, st, r);
      check("speed shadow", 32'h0, 32'(st[15:8]));
      check("array shadow", 32'h0, 32'(st[23:16]));
      op(1'b0, FA_ARRAY, 8'h00, st);
      rd(OFS_RESULT, d, r);
      check("array after power", 32'h0, d);
      op(1'b0, FA_SPEED, 8'h00, st);
      rd(OFS_RESULT, d, r);
      check("speed after power", 32'h0, d);
      op(1'b0, FA_DRIVE, 8'h00, st);
      rd(OFS_RESULT, d, r);
      check("drive after power", 32'h0, d);
      op(1'b0, FA_RB_PULL, 8'h00, st);
      rd(OFS_RESULT, d, r);
      check("pull-down after power", 32'h0, d);
      $display("test defaults pass %0d done", k);
      if (k == 1) break;
      rd(8'h10, d, r);
      check("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
      check("unmapped read data", 32'h0, d);
      wr(8'h20, 32'hFFFFFFFF, r);
      check("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
      for (int i = 0; i < 22; i++) begin
        exp = t_p1[i] & (t_fa[i] == FA_SPEED ? MASK_SPEED :
                         t_fa[i] == FA_ARRAY ? MASK_ARRAY : MASK_STRENGTH);
        op(1'b1, t_fa[i], t_p1[i], st);
        check("set done", 32'h1, 32'(st[ST_DONE]));
        check("device byte", 32'(exp), 32'(flash.feat[t_fa[i]]));
        check("device trailing bytes", 32'h0, 32'(flash.extra_or));
        op(1'b0, t_fa[i], 8'h00, st);
        rd(OFS_RESULT, d, r);
        check("get result", {24'h0, exp}, d);
        if (t_fa[i] == FA_SPEED) check("speed shadow", 32'(exp), 32'(st[15:8]));
        if (t_fa[i] == FA_ARRAY) check("array shadow", 32'(exp), 32'(st[23:16]));
      end
      $display("test feature table done");
      foreach (rsv[i]) begin
        n = ce_falls;
        op(1'b1, rsv[i], 8'h01, st);
        check("reserved refused", 32'h1, 32'(st[ST_REFUSED]));
        check("reserved pin idle", 32'(n), 32'(ce_falls));
      end
      force_busy <= 1'b1;
      n = ce_falls;
      op(1'b0, FA_SPEED, 8'h00, st);
      check("busy get refused", 32'h1, 32'(st[ST_REFUSED]));
      check("busy pin idle", 32'(n), 32'(ce_falls));
      force_busy <= 1'b0;
      $display("test refusals done");
      power_cycle <= 1'b1;
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      power_cycle <= 1'b0;
      aresetn <= 1'b1;
    end
    tally_and_finish();
  end
endmodule // tb_feature_parameter_access
`default_nettype wire
